// ---- hdl/mbfr_pkg.sv ----
// shared constants of the motor bridge fault response block
package mbfr_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W    = 2;
  localparam int          DATA_W    = 16;
  localparam logic [1:0]  REG_CTRL  = 2'h0;
  localparam logic [1:0]  REG_STAT  = 2'h1;
  localparam logic [1:0]  REG_DIAG  = 2'h2;
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  // control bits
  localparam int C_RUN   = 0;
  localparam int C_ESF   = 1;
  localparam int C_RSC   = 2;
  localparam int C_DSR   = 3;
  localparam int C_LRMSK = 4;
  localparam int C_W     = 5;
  // status bits
  localparam int S_SYS   = 0;
  localparam int S_SER   = 1;
  localparam int S_POR   = 2;
  localparam int S_MSUV  = 3;
  localparam int S_LRUV  = 4;
  localparam int S_GRUV  = 5;
  localparam int S_BOOT  = 6;
  localparam int S_TWARN = 7;
  localparam int S_OT    = 8;
  localparam int S_SYNC  = 9;
  localparam int S_VDS   = 10;
  localparam int S_REARM = 11;
  localparam int S_OFF   = 12;
  // diagnostic bits
  localparam int D_MASK  = 0;
  localparam int D_HRST  = 6;
  localparam int D_LREN  = 7;
  // ----------------------------------------------------------------
  // bridge and timing
  // ----------------------------------------------------------------
  localparam int          N_FET        = 6;
  localparam int          DEMAND_W     = 8;
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned HRST_DLY_MS  = 10;
  localparam int unsigned HRST_DLY_CYC = CLK_HZ / 1000 * HRST_DLY_MS;
endpackage

// ---- hdl/mbfr_tmr_if.sv ----
// carrier between the fault controller and its host reset timer
`timescale 1ns/1ps
`default_nettype none
interface mbfr_tmr_if;
  logic arm;
  logic done;
  logic busy;
  modport ctrl (output arm, input done, input busy);
  modport tmr  (input arm, output done, output busy);
endinterface
`default_nettype wire

// ---- hdl/mbfr_rst_timer.sv ----
// host reset hold timer: holds while armed, then counts a fixed delay
`timescale 1ns/1ps
`default_nettype none
module mbfr_rst_timer #(
  parameter int unsigned DLY_CYC = mbfr_pkg::HRST_DLY_CYC
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // controller side
  mbfr_tmr_if.tmr   t
);
  localparam int CW = $clog2(DLY_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(DLY_CYC - 1);

  typedef enum logic [2:0] {
    MBFR_IDLE  = 3'h1,
    MBFR_HOLD  = 3'h2,
    MBFR_COUNT = 3'h4
  } mbfr_tstate_e;

  mbfr_tstate_e  st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          done_q, done_d;
  logic          busy_q, busy_d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    done_d = 1'b0;
    unique case (st_q)
      MBFR_IDLE: begin
        if (t.arm) begin
          st_d = MBFR_HOLD;
        end
      end
      MBFR_HOLD: begin
        cnt_d = '0;
        if (!t.arm) begin
          st_d = MBFR_COUNT;
        end
      end
      MBFR_COUNT: begin
        // a returning condition restarts the whole delay
        if (t.arm) begin
          st_d = MBFR_HOLD;
        end else if (cnt_q == LAST) begin
          st_d   = MBFR_IDLE;
          done_d = 1'b1;
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
      default: begin
        st_d = MBFR_IDLE;
      end
    endcase
    busy_d = (st_d != MBFR_IDLE);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q   <= MBFR_IDLE;
      cnt_q  <= '0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
      busy_q <= busy_d;
    end
  end

  assign t.done = done_q;
  assign t.busy = busy_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  count_bound_a: assert property (
    (st_q == MBFR_COUNT) |-> (cnt_q <= LAST))
    else $error("reset delay counter ran past its end");
endmodule
`default_nettype wire

// ---- hdl/mbfr_fault_ctrl.sv ----
// fault response controller for a three-phase bridge gate driver
`timescale 1ns/1ps
`default_nettype none
module mbfr_fault_ctrl #(
  parameter int unsigned DLY_CYC  = mbfr_pkg::HRST_DLY_CYC,
  parameter int          DEMAND_W = mbfr_pkg::DEMAND_W
) (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // register port
  input  wire logic [mbfr_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [mbfr_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [mbfr_pkg::DATA_W-1:0] reg_rdata,
  // demand and gate commands
  input  wire logic [DEMAND_W-1:0]         demand,
  input  wire logic [mbfr_pkg::N_FET-1:0]  gate_cmd,
  // fault conditions
  input  wire logic                        sys_err,
  input  wire logic                        serial_err,
  input  wire logic                        main_supply_por,
  input  wire logic                        main_supply_uv,
  input  wire logic                        logic_regulator_uv,
  input  wire logic                        gate_regulator_uv,
  input  wire logic [mbfr_pkg::N_FET-1:0]  boot_uv,
  input  wire logic                        temp_warn,
  input  wire logic                        over_temp,
  input  wire logic                        sync_loss,
  input  wire logic [mbfr_pkg::N_FET-1:0]  vds_ov,
  // outputs
  output logic      [mbfr_pkg::N_FET-1:0]  gate_out,
  output logic                             host_reset_out_n,
  output logic                             logic_regulator_en
);
  localparam int NF = mbfr_pkg::N_FET;
  localparam int DW = mbfr_pkg::DATA_W;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [mbfr_pkg::C_W-1:0] ctrl_q, ctrl_d;
  logic [DW-1:0] lat_q, lat_d;
  logic [NF-1:0] mask_q, mask_d, cmd_q, gate_q, gate_d;
  logic [DW-1:0] rdata_q, rdata_d;
  logic          hrst_n_q, lren_q;
  logic          stop_on_fault_enable, sync_loss_restart, dsr, lrmsk, run;
  logic          rd_clear, act_clear, dis_all, drive_ok, run_set;
  logic [NF-1:0] part_set, mask_eff;

  mbfr_tmr_if tif ();

  mbfr_rst_timer #(.DLY_CYC(DLY_CYC)) u_tmr (
    .core_clk (core_clk),
    .rst      (rst),
    .t        (tif)
  );

  assign stop_on_fault_enable   = ctrl_q[mbfr_pkg::C_ESF];
  assign sync_loss_restart   = ctrl_q[mbfr_pkg::C_RSC];
  assign dsr   = ctrl_q[mbfr_pkg::C_DSR];
  assign lrmsk = ctrl_q[mbfr_pkg::C_LRMSK];
  assign run   = ctrl_q[mbfr_pkg::C_RUN];

  // the host reset timer stays held while either source persists
  assign tif.arm = (logic_regulator_uv & ~lrmsk) | (over_temp & stop_on_fault_enable);

  // ----------------------------------------------------------------
  // fault response
  // ----------------------------------------------------------------
  always_comb begin
    rd_clear = reg_rd & ~dsr &
               (reg_addr == mbfr_pkg::REG_STAT ||
                reg_addr == mbfr_pkg::REG_DIAG);
    // demand zero and run zero also block drive, so the re-enable
    // step is simply taking them back up
    act_clear = rd_clear | (demand == '0) | ~run;
    run_set = reg_wr && reg_addr == mbfr_pkg::REG_CTRL &&
              reg_wdata[mbfr_pkg::C_RUN];
    ctrl_d = ctrl_q;
    if (reg_wr && reg_addr == mbfr_pkg::REG_CTRL) begin
      ctrl_d = reg_wdata[mbfr_pkg::C_W-1:0];
    end
    lat_d = lat_q;
    // every sticky bit: clear first, so that a set in the same cycle wins
    if (act_clear) begin
      lat_d[mbfr_pkg::S_MSUV]  = 1'b0;
      lat_d[mbfr_pkg::S_BOOT]  = 1'b0;
      lat_d[mbfr_pkg::S_VDS]   = 1'b0;
      lat_d[mbfr_pkg::S_SYNC]  = 1'b0;
      lat_d[mbfr_pkg::S_REARM] = 1'b0;
    end
    if (rd_clear) begin
      lat_d[mbfr_pkg::S_SER] = 1'b0;
    end
    if (run_set) begin
      lat_d[mbfr_pkg::S_SYS] = 1'b0;
    end
    if (tif.done) begin
      lat_d[mbfr_pkg::S_LRUV]  = 1'b0;
      lat_d[mbfr_pkg::S_OT]    = 1'b0;
      lat_d[mbfr_pkg::S_REARM] = 1'b1;
    end
    if (main_supply_uv & ~sync_loss_restart) begin
      lat_d[mbfr_pkg::S_MSUV] = 1'b1;
    end
    if ((|boot_uv) & stop_on_fault_enable) begin
      lat_d[mbfr_pkg::S_BOOT] = 1'b1;
    end
    if ((|vds_ov) & stop_on_fault_enable) begin
      lat_d[mbfr_pkg::S_VDS] = 1'b1;
    end
    if (sync_loss & ~sync_loss_restart) begin
      lat_d[mbfr_pkg::S_SYNC] = 1'b1;
    end
    if (logic_regulator_uv & ~lrmsk) begin
      lat_d[mbfr_pkg::S_LRUV] = 1'b1;
    end
    if (over_temp & stop_on_fault_enable) begin
      lat_d[mbfr_pkg::S_OT] = 1'b1;
    end
    if (serial_err) begin
      lat_d[mbfr_pkg::S_SER] = 1'b1;
    end
    if (sys_err) begin
      lat_d[mbfr_pkg::S_SYS] = 1'b1;
      ctrl_d[mbfr_pkg::C_RUN] = 1'b0;
    end
    // supply por wipes run and every latch; drive needs a new run write
    if (main_supply_por) begin
      lat_d  = '0;
      ctrl_d[mbfr_pkg::C_RUN] = 1'b0;
    end
    // level flags follow their condition
    lat_d[mbfr_pkg::S_POR]   = main_supply_por;
    lat_d[mbfr_pkg::S_GRUV]  = gate_regulator_uv;
    lat_d[mbfr_pkg::S_TWARN] = temp_warn;
    // per-gate masks without stop-on-fault, cleared by next pwm on
    part_set = (boot_uv | vds_ov) & {NF{~stop_on_fault_enable}};
    mask_d   = (mask_q & ~(gate_cmd & ~cmd_q)) | part_set;
    mask_eff = mask_q | part_set;
    dis_all = main_supply_por | gate_regulator_uv |
              lat_q[mbfr_pkg::S_SYS] | lat_q[mbfr_pkg::S_SYNC] |
              (sync_loss & sync_loss_restart) |
              (stop_on_fault_enable & (lat_q[mbfr_pkg::S_MSUV] |
                      lat_q[mbfr_pkg::S_BOOT] | lat_q[mbfr_pkg::S_VDS] |
                      (main_supply_uv & sync_loss_restart))) |
              lat_q[mbfr_pkg::S_LRUV] | lat_q[mbfr_pkg::S_OT] |
              lat_q[mbfr_pkg::S_REARM];
    drive_ok = run & (demand != '0) & ~dis_all;
    gate_d   = drive_ok ? (gate_cmd & ~mask_eff) : '0;
    lat_d[mbfr_pkg::S_OFF] = ~drive_ok;
    rdata_d = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        mbfr_pkg::REG_CTRL: rdata_d = DW'(ctrl_q);
        mbfr_pkg::REG_STAT: rdata_d = lat_q;
        mbfr_pkg::REG_DIAG: begin
          rdata_d[mbfr_pkg::D_MASK +: NF] = mask_q;
          rdata_d[mbfr_pkg::D_HRST]       = hrst_n_q;
          rdata_d[mbfr_pkg::D_LREN]       = lren_q;
        end
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_q   <= mbfr_pkg::CTRL_RST[mbfr_pkg::C_W-1:0];
      lat_q    <= '0;
      mask_q   <= '0;
      cmd_q    <= '0;
      gate_q   <= '0;
      rdata_q  <= '0;
      hrst_n_q <= 1'b0;
      lren_q   <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      lat_q    <= lat_d;
      mask_q   <= mask_d;
      cmd_q    <= gate_cmd;
      gate_q   <= gate_d;
      rdata_q  <= rdata_d;
      hrst_n_q <= ~tif.busy;
      lren_q   <= ~lat_q[mbfr_pkg::S_OT];
    end
  end

  assign reg_rdata          = rdata_q;
  assign gate_out           = gate_q;
  assign host_reset_out_n   = hrst_n_q;
  assign logic_regulator_en = lren_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence vds_off_s;
    lat_q[mbfr_pkg::S_VDS] ##1 (gate_out == '0);
  endsequence
  sequence ot_off_s;
    lat_q[mbfr_pkg::S_OT] ##1 (!logic_regulator_en && !host_reset_out_n);
  endsequence

  all_off_a: assert property (dis_all |=> gate_out == '0)
    else $error("gates not all low under full disable");
  partial_a: assert property (
    drive_ok |=> gate_out == ($past(gate_cmd) & ~$past(mask_eff)))
    else $error("partial disable touched wrong gate");
  read_clear_a: assert property (
    (rd_clear && !main_supply_uv && !main_supply_por)
      |=> !lat_q[mbfr_pkg::S_MSUV])
    else $error("status read did not clear latch");
  dsr_hold_a: assert property (
    (dsr && run && demand != '0 && lat_q[mbfr_pkg::S_MSUV] &&
     !main_supply_por) |=> lat_q[mbfr_pkg::S_MSUV])
    else $error("latch cleared although read reset disabled");
  esf_vds_a: assert property (
    (stop_on_fault_enable && vds_ov != '0 && !main_supply_por) |=> vds_off_s)
    else $error("vds fault not latched and disabled");
  no_esf_ot_a: assert property (
    (!stop_on_fault_enable && !lat_q[mbfr_pkg::S_OT]) |=> !lat_q[mbfr_pkg::S_OT])
    else $error("overtemp latched without stop-on-fault");
  por_reset_a: assert property (
    main_supply_por |=> (!run && lat_q[mbfr_pkg::S_SYNC] == 1'b0)
      ##1 gate_out == '0)
    else $error("por did not reset logic and gates");
  hrst_rel_a: assert property (
    tif.done |=> (!lat_q[mbfr_pkg::S_LRUV] && host_reset_out_n))
    else $error("host reset not released with latch clear");
  ot_esf_a: assert property (
    (over_temp && stop_on_fault_enable && !main_supply_por) |=> ot_off_s)
    else $error("overtemp did not shut regulator and reset host");
  msuv_keep_a: assert property (
    (!stop_on_fault_enable && !sync_loss_restart && main_supply_uv && !main_supply_por && run &&
     demand != '0 && !dis_all) |=> (lat_q[mbfr_pkg::S_MSUV] &&
     gate_out == ($past(gate_cmd) & ~$past(mask_eff))))
    else $error("supply uv must latch but keep drive");
  sync_lat_a: assert property (
    (sync_loss && !sync_loss_restart && !main_supply_por) |=> lat_q[mbfr_pkg::S_SYNC])
    else $error("sync loss not latched");
  rearm_a: assert property (
    (lat_q[mbfr_pkg::S_REARM] && !act_clear && !main_supply_por)
      |=> lat_q[mbfr_pkg::S_REARM])
    else $error("re-enable gate dropped without host action");
  gruv_off_a: assert property (
    gate_regulator_uv |=> gate_out == '0)
    else $error("gate regulator uv left gates on");
endmodule
`default_nettype wire

// ---- tb/mbfr_host_model.sv ----
// host microcontroller model driving the register port and demand input
`timescale 1ns/1ps
`default_nettype none
module mbfr_host_model (
  // clock
  input  wire logic                        core_clk,
  // register port
  output var  logic [mbfr_pkg::ADDR_W-1:0] reg_addr,
  output var  logic [mbfr_pkg::DATA_W-1:0] reg_wdata,
  output var  logic                        reg_wr,
  output var  logic                        reg_rd,
  input  wire logic [mbfr_pkg::DATA_W-1:0] reg_rdata,
  // demand
  output var  logic [7:0]                  demand
);
  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  initial begin
    reg_addr  = 2'h0;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    demand    = 8'h00;
  end
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    // stale data must never look like a valid write
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // ----------------------------------------------------------------
  // re-enable sequences
  // ----------------------------------------------------------------
  task automatic dem(input logic [7:0] v);
    @(posedge core_clk);
    demand <= v;
  endtask
  task automatic dem_reset(input logic [7:0] v);
    dem(8'h00);
    dem(v);
  endtask
  task automatic run_reset(input logic [15:0] c);
    wr(mbfr_pkg::REG_CTRL, c & 16'hFFFE);
    wr(mbfr_pkg::REG_CTRL, c | 16'h0001);
  endtask
endmodule
`default_nettype wire

// ---- tb/motor_bridge_fault_response_tb.sv ----
// self-checking bench of the fault response controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module motor_bridge_fault_response_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic [5:0]  gate_cmd = 6'h15;
  // fault order: sys ser por msuv lruv gruv tw ot sync boot[6] vds[6]
  logic [20:0] flt      = 21'h000000;
  logic [1:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [7:0]  demand;
  logic [5:0]  gate_out;
  logic        hrst_n;
  logic        lr_en;
  logic [15:0] d;
  int          n;
  int          n_mismatch = 0;
  int          compares   = 0;
  always #5 core_clk = ~core_clk;
  // short delay keeps the host reset walk inside a few cycles
  mbfr_fault_ctrl #(.DLY_CYC(20)) dut (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .demand(demand), .gate_cmd(gate_cmd),
    .sys_err(flt[0]), .serial_err(flt[1]), .main_supply_por(flt[2]),
    .main_supply_uv(flt[3]), .logic_regulator_uv(flt[4]),
    .gate_regulator_uv(flt[5]), .temp_warn(flt[6]),
    .over_temp(flt[7]), .sync_loss(flt[8]), .boot_uv(flt[14:9]),
    .vds_ov(flt[20:15]), .gate_out(gate_out),
    .host_reset_out_n(hrst_n), .logic_regulator_en(lr_en));
  mbfr_host_model host (
    .core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .demand(demand));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (n_mismatch == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic setf(input logic [20:0] v);
    @(posedge core_clk);
    flt <= v;
    tick(3);
  endtask
  task automatic wait_hrst();
    n = 0;
    while (hrst_n !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    if (n >= 100) begin
      n_mismatch++;
      $display("unexpected at %0t: host reset stuck low", $time);
      stop_test();
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    tick(2);
    `CHK(hrst_n, 1'b1)
    host.rd(mbfr_pkg::REG_CTRL, d);
    `CHK(d, 16'h0000)
    host.rd(2'h3, d);
    `CHK(d, 16'h0000)
    host.wr(mbfr_pkg::REG_CTRL, 16'h0003);
    host.dem(8'h40);
    tick(3);
    `CHK(gate_out, 6'h15)
    setf(21'h008000);
    `CHK(gate_out, 6'h00)
    setf(21'h000000);
    `CHK(gate_out, 6'h00)
    host.rd(mbfr_pkg::REG_STAT, d);
    `CHK(d[mbfr_pkg::S_VDS], 1'b1)
    tick(3);
    `CHK(gate_out, 6'h15)
    // read clearing disabled: reads leave drive off until a demand reset brings it back
    host.wr(mbfr_pkg::REG_CTRL, 16'h000B);
    setf(21'h000408);
    setf(21'h000000);
    host.rd(mbfr_pkg::REG_STAT, d);
    host.rd(mbfr_pkg::REG_STAT, d);
    `CHK(d[mbfr_pkg::S_MSUV], 1'b1)
    tick(3);
    `CHK(gate_out, 6'h00)
    host.dem_reset(8'h40);
    tick(3);
    `CHK(gate_out, 6'h15)
    setf(21'h000100);
    setf(21'h000000);
    `CHK(gate_out, 6'h00)
    host.run_reset(16'h000B);
    tick(3);
    `CHK(gate_out, 6'h15)
    host.wr(mbfr_pkg::REG_CTRL, 16'h0007);
    setf(21'h000100);
    `CHK(gate_out, 6'h00)
    setf(21'h000000);
    `CHK(gate_out, 6'h15)
    host.wr(mbfr_pkg::REG_CTRL, 16'h0003);
    setf(21'h000080);
    `CHK({gate_out, lr_en, hrst_n}, 8'h00)
    setf(21'h000000);
    wait_hrst();
    `CHK(n >= 17 && n <= 26, 1'b1)
    host.rd(mbfr_pkg::REG_STAT, d);
    tick(3);
    `CHK({gate_out, lr_en}, 7'h2B)
    setf(21'h000010);
    `CHK({gate_out, hrst_n}, 7'h00)
    setf(21'h000000);
    wait_hrst();
    `CHK(n >= 17 && n <= 26, 1'b1)
    host.rd(mbfr_pkg::REG_DIAG, d);
    tick(3);
    `CHK(gate_out, 6'h15)
    setf(21'h000004);
    `CHK(gate_out, 6'h00)
    setf(21'h000000);
    host.rd(mbfr_pkg::REG_CTRL, d);
    `CHK({gate_out, d[mbfr_pkg::C_RUN]}, 7'h00)
    host.wr(mbfr_pkg::REG_CTRL, 16'h0003);
    tick(3);
    `CHK(gate_out, 6'h15)
    host.wr(mbfr_pkg::REG_CTRL, 16'h0001);
    setf(21'h020000);
    `CHK(gate_out, 6'h11)
    setf(21'h000000);
    `CHK(gate_out, 6'h11)
    host.rd(mbfr_pkg::REG_DIAG, d);
    `CHK(d[7:0], 8'hC4)
    @(posedge core_clk);
    gate_cmd <= 6'h11;
    @(posedge core_clk);
    gate_cmd <= 6'h15;
    tick(3);
    `CHK(gate_out, 6'h15)
    setf(21'h000088);
    `CHK(gate_out, 6'h15)
    setf(21'h000000);
    host.rd(mbfr_pkg::REG_STAT, d);
    `CHK(d[mbfr_pkg::S_MSUV], 1'b1)
    host.rd(mbfr_pkg::REG_STAT, d);
    `CHK(d[mbfr_pkg::S_MSUV], 1'b0)
    // common faults must not care about the stop-on-fault setting
    for (int e = 0; e < 2; e++) begin
      host.wr(mbfr_pkg::REG_CTRL, 16'(2 * e + 1));
      setf(21'h000022);
      `CHK(gate_out, 6'h00)
      setf(21'h000000);
      `CHK(gate_out, 6'h15)
      setf(21'h000001);
      setf(21'h000000);
      host.rd(mbfr_pkg::REG_CTRL, d);
      `CHK({gate_out, d[mbfr_pkg::C_RUN]}, 7'h00)
      host.wr(mbfr_pkg::REG_CTRL, 16'(2 * e + 1));
      tick(3);
      `CHK(gate_out, 6'h15)
    end
    stop_test();
  end
endmodule
`undef CHK
`default_nettype wire
